// ===== rtl/sio_pkg.sv
`default_nettype none
package sio_pkg;
  // ==========================================================
  // Bus and register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] SHIFT_IDX = 8'h01;
  localparam logic [7:0] SHIFT_ADDR = 8'h04;
  localparam logic [7:0] CTRL_ADDR = 8'h08;
  localparam logic [7:0] STAT_ADDR = 8'h0C;
  localparam logic [7:0] MASK_ADDR = 8'h10;
  localparam logic [7:0] PORT_ADDR = 8'h14;
  // ==========================================================
  // Control, status and port fields
  localparam int CTRL_SEL_LO = 0;
  localparam int CTRL_SEL_HI = 1;
  localparam int CTRL_PIN_EN = 2;
  localparam int CTRL_FLOAT = 3;
  localparam int CTRL_GO = 4;
  localparam int STAT_DONE = 0;
  localparam int STAT_BUSY = 1;
  localparam int PORT_DIR_LSB = 4;
  localparam int PORT_PIN_LSB = 8;
  localparam logic [1:0] SEL_EXT = 2'h0;
  localparam logic [1:0] SEL_D16 = 2'h1;
  localparam logic [1:0] SEL_D128 = 2'h2;
  localparam logic [1:0] SEL_D1024 = 2'h3;
  // ==========================================================
  // Reset values
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [2:0] LATCH_RST = 3'h7;
  localparam logic [2:0] DIR_RST = 3'h0;
  localparam logic MASK_RST = 1'b0;
  // ==========================================================
  // Timing: shift clock periods and half periods in system clocks
  localparam int DIV16 = 16;
  localparam int DIV128 = 128;
  localparam int DIV1024 = 1024;
  localparam logic [9:0] HALF16 = 10'(DIV16 / 2);
  localparam logic [9:0] HALF128 = 10'(DIV128 / 2);
  localparam logic [9:0] HALF1024 = 10'(DIV1024 / 2);
  localparam logic [2:0] LAST_BIT = 3'h7;
endpackage
`default_nettype wire

// ===== rtl/serial_clock_gen.sv
`timescale 1ns/100ps
`default_nettype none
module serial_clock_gen (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] sel,
  input wire logic run,
  input wire logic ext_sck,
  output logic sck_r,
  output logic fall_r,
  output logic rise_r
);
  import sio_pkg::*;
  // ==========================================================
  // Divider and external clock sync
  logic [9:0] cnt_r;
  logic [9:0] half;
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic ext_sel;
  logic wrap;
  assign ext_sel = (sel == SEL_EXT);
  assign half = (sel == SEL_D16) ? HALF16 :
                (sel == SEL_D128) ? HALF128 : HALF1024; // [R1]
  assign wrap = (cnt_r == half - 10'h001);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      sync3_r <= 1'b1;
    end else begin
      sync1_r <= ext_sck; // [R16]
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 10'h000;
      sck_r <= 1'b1;
      fall_r <= 1'b0;
      rise_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= 10'h000;
      sck_r <= 1'b1;
      fall_r <= 1'b0;
      rise_r <= 1'b0;
    end else if (ext_sel) begin
      fall_r <= sync3_r & ~sync2_r; // [R16]
      rise_r <= ~sync3_r & sync2_r;
    end else begin
      cnt_r <= wrap ? 10'h000 : cnt_r + 10'h001;
      sck_r <= wrap ? ~sck_r : sck_r;
      fall_r <= wrap & sck_r; // [R4]
      rise_r <= wrap & ~sck_r;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/clocked_serial_shift_port.sv
// Behaviour
// R1: Two-bit select: external, /16, /128, /1024
// R2: Internal shift clock driven out on clock pin
// R3: Pin enable hands three pins to serial
// R4: Go starts eight bits at next falling edge
// R5: Setting go clears the done request
// R6: Falling edge puts shift MSB on data-out
// R7: Rising edge shifts, data-in into LSB
// R8: Three-bit counter, eighth clock sets done
// R9: After eight bits go clears itself
// R10: Enable and float bits choose the mode
// R11: Float holds data-out undriven, receive only
// R12: Data-in sampled in every serial mode
// R13: Data-out latch shared with port latch
// R14: Go low: no shifting, plain register
// R15: Shift register at index 01, low byte
// R16: External clock synchronised, edges detected
// R17: Remote gives eight clocks, MSB-first timing
`timescale 1ns/100ps
`default_nettype none
module clocked_serial_shift_port (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sio_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic port_d_line0_in,
  output logic port_d_line0_out,
  output logic port_d_line0_oe_n,
  input wire logic port_d_line1_in,
  output logic port_d_line1_out,
  output logic port_d_line1_oe_n,
  input wire logic port_d_line2_in,
  output logic port_d_line2_out,
  output logic port_d_line2_oe_n
);
  import sio_pkg::*;
  // ==========================================================
  // State
  logic [7:0] serial_shift_reg_r;
  logic [1:0] clk_sel_r;
  logic serial_pin_enable_r;
  logic tx_output_float_r;
  logic transfer_go_r;
  logic serial_done_request_r;
  logic mask_r;
  logic [2:0] latch_r;
  logic [2:0] dir_r;
  logic [2:0] bit_cnt_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic irq_r;
  logic [2:0] pin_out_r;
  logic [2:0] pin_oe_n_r;
  logic sck;
  logic fall_p;
  logic rise_p;
  // ==========================================================
  // Bus decode
  logic acc;
  logic wr;
  logic rd;
  logic hit_shift;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_mask;
  logic hit_port;
  logic mapped;
  logic go_write;
  logic last_rise;
  logic [31:0] rd_mux;
  logic [2:0] pins_in;
  assign acc = psel & penable & pready_r;
  assign wr = acc & pwrite;
  assign rd = psel & penable & ~pready_r & ~pwrite;
  assign hit_shift = (paddr == SHIFT_ADDR); // [R15]
  assign hit_ctrl = (paddr == CTRL_ADDR);
  assign hit_stat = (paddr == STAT_ADDR);
  assign hit_mask = (paddr == MASK_ADDR);
  assign hit_port = (paddr == PORT_ADDR);
  assign mapped = hit_shift | hit_ctrl | hit_stat | hit_mask | hit_port;
  assign go_write = wr & hit_ctrl & pwdata[CTRL_GO] &
                    serial_pin_enable_r & ~transfer_go_r; // [R4]
  assign last_rise = transfer_go_r & rise_p &
                     (bit_cnt_r == LAST_BIT); // [R8]
  assign pins_in = {port_d_line2_in, port_d_line1_in, port_d_line0_in};
  assign rd_mux = hit_shift ? {24'h0, serial_shift_reg_r} :
    hit_ctrl ? {27'h0, transfer_go_r, tx_output_float_r,
                serial_pin_enable_r, clk_sel_r} :
    hit_stat ? {30'h0, transfer_go_r, serial_done_request_r} :
    hit_mask ? {31'h0, mask_r} :
    hit_port ? {21'h0, pins_in, 1'b0, dir_r, 1'b0, latch_r} : 32'h0;

  // ==========================================================
  // Shift clock source
  serial_clock_gen u_clk (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sel(clk_sel_r),
    .run(transfer_go_r),
    .ext_sck(port_d_line0_in),
    .sck_r(sck),
    .fall_r(fall_p),
    .rise_r(rise_p)
  );

  // ==========================================================
  // APB slave
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~mapped;
      prdata_r <= rd ? rd_mux : 32'h0;
    end
  end

  // ==========================================================
  // Control, mask and port direction registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel_r <= SEL_EXT;
      serial_pin_enable_r <= 1'b0;
      tx_output_float_r <= 1'b0;
      mask_r <= MASK_RST;
      dir_r <= DIR_RST;
    end else begin
      if (wr & hit_ctrl & ~transfer_go_r) begin
        clk_sel_r <= pwdata[CTRL_SEL_HI:CTRL_SEL_LO]; // [R1]
        serial_pin_enable_r <= pwdata[CTRL_PIN_EN]; // [R3]
        tx_output_float_r <= pwdata[CTRL_FLOAT]; // [R10]
      end
      if (wr & hit_mask) begin
        mask_r <= pwdata[0];
      end
      if (wr & hit_port) begin
        dir_r <= pwdata[PORT_DIR_LSB+2:PORT_DIR_LSB];
      end
    end
  end

  // ==========================================================
  // Transfer control
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      transfer_go_r <= 1'b0;
      bit_cnt_r <= 3'h0;
      serial_done_request_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      if (go_write) begin
        transfer_go_r <= 1'b1; // [R4]
      end else if (last_rise) begin
        transfer_go_r <= 1'b0; // [R9]
      end
      if (go_write) begin
        bit_cnt_r <= 3'h0;
      end else if (transfer_go_r & rise_p) begin
        bit_cnt_r <= bit_cnt_r + 3'h1; // [R8]
      end
      if (last_rise) begin
        serial_done_request_r <= 1'b1; // [R8] [R9]
      end else if (go_write | (rd & hit_stat)) begin
        serial_done_request_r <= 1'b0; // [R5]
      end
      irq_r <= (serial_done_request_r | last_rise) & mask_r;
    end
  end

  // ==========================================================
  // Shift register and shared data-out latch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_shift_reg_r <= SHIFT_RST;
      latch_r <= LATCH_RST;
    end else begin
      if (transfer_go_r & rise_p) begin
        serial_shift_reg_r <= {serial_shift_reg_r[6:0],
                               port_d_line2_in}; // [R7] [R12]
      end else if (wr & hit_shift & ~transfer_go_r) begin
        serial_shift_reg_r <= pwdata[7:0]; // [R14] [R15]
      end
      if (transfer_go_r & fall_p) begin
        latch_r[1] <= serial_shift_reg_r[7]; // [R6] [R13]
      end else if (wr & hit_port) begin
        latch_r <= pwdata[2:0]; // [R13]
      end
    end
  end

  // ==========================================================
  // Pin drivers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_r <= LATCH_RST;
      pin_oe_n_r <= 3'h7;
    end else if (serial_pin_enable_r) begin
      pin_out_r <= {latch_r[2], latch_r[1], sck};
      pin_oe_n_r[0] <= (clk_sel_r == SEL_EXT); // [R2] [R3]
      pin_oe_n_r[1] <= tx_output_float_r; // [R10] [R11]
      pin_oe_n_r[2] <= 1'b1; // [R12]
    end else begin
      pin_out_r <= latch_r; // [R10]
      pin_oe_n_r <= ~dir_r;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign port_d_line0_out = pin_out_r[0];
  assign port_d_line1_out = pin_out_r[1];
  assign port_d_line2_out = pin_out_r[2];
  assign port_d_line0_oe_n = pin_oe_n_r[0];
  assign port_d_line1_oe_n = pin_oe_n_r[1];
  assign port_d_line2_oe_n = pin_oe_n_r[2];

  // ==========================================================
  // Checks
  a_go_clears_done: assert property (@(posedge sys_clk) // [R5]
    disable iff (!rst_n) go_write |=> !serial_done_request_r)
    else $error("done request not cleared by go");
  a_done_at_end: assert property (@(posedge sys_clk) // [R8]
    disable iff (!rst_n) last_rise |=> serial_done_request_r
      && !transfer_go_r)
    else $error("done not set or go not cleared at end");
  a_go_self_clear: assert property (@(posedge sys_clk) // [R9]
    disable iff (!rst_n) $fell(transfer_go_r) |->
      $past(bit_cnt_r) == LAST_BIT && $past(rise_p))
    else $error("go cleared before eighth clock");
  a_msb_out: assert property (@(posedge sys_clk) // [R6]
    disable iff (!rst_n) transfer_go_r && fall_p |=>
      latch_r[1] == $past(serial_shift_reg_r[7]))
    else $error("data-out latch not MSB on falling edge");
  a_lsb_capture: assert property (@(posedge sys_clk) // [R7]
    disable iff (!rst_n) transfer_go_r && rise_p |=>
      serial_shift_reg_r == {$past(serial_shift_reg_r[6:0]),
                             $past(port_d_line2_in)})
    else $error("shift on rising edge wrong");
  a_idle_no_shift: assert property (@(posedge sys_clk) // [R14]
    disable iff (!rst_n) !transfer_go_r && !(wr && hit_shift) |=>
      $stable(serial_shift_reg_r))
    else $error("shift register moved while idle");
  a_float_hiz: assert property (@(posedge sys_clk) // [R11]
    disable iff (!rst_n) serial_pin_enable_r && tx_output_float_r
      |=> port_d_line1_oe_n)
    else $error("data-out driven while floating");
  a_sck_drive: assert property (@(posedge sys_clk) // [R2]
    disable iff (!rst_n) serial_pin_enable_r && clk_sel_r != SEL_EXT
      |=> !port_d_line0_oe_n && port_d_line0_out == $past(sck))
    else $error("internal clock not driven out");
  a_div16_half: assert property (@(posedge sys_clk) // [R1]
    disable iff (!rst_n) transfer_go_r && clk_sel_r == SEL_D16
      && !last_rise && $rose(sck) |-> ##8 !sck)
    else $error("divide by 16 half period wrong");
  a_si_pin_input: assert property (@(posedge sys_clk) // [R12]
    disable iff (!rst_n) serial_pin_enable_r |=> port_d_line2_oe_n)
    else $error("data-in pin driven in serial mode");
  a_gp_port_mode: assert property (@(posedge sys_clk) // [R10]
    disable iff (!rst_n) !serial_pin_enable_r |=>
      port_d_line1_out == $past(latch_r[1])
      && port_d_line1_oe_n == !$past(dir_r[1]))
    else $error("port mode pin not from latch");
  a_go_needs_pins: assert property (@(posedge sys_clk) // [R4]
    disable iff (!rst_n) $rose(transfer_go_r) |->
      $past(serial_pin_enable_r))
    else $error("transfer started with pins disabled");
  a_latch_port_write: assert property (@(posedge sys_clk) // [R13]
    disable iff (!rst_n) wr && hit_port && !(transfer_go_r && fall_p)
      |=> latch_r == $past(pwdata[2:0]))
    else $error("port write missed shared latch");
  a_shift_write: assert property (@(posedge sys_clk) // [R15]
    disable iff (!rst_n) wr && hit_shift && !transfer_go_r |=>
      serial_shift_reg_r == $past(pwdata[7:0]))
    else $error("shift register write lost");
  a_ext_fall_sync: assert property (@(posedge sys_clk) // [R16]
    disable iff (!rst_n) clk_sel_r == SEL_EXT && fall_p |->
      $past(port_d_line0_in, 4) && !$past(port_d_line0_in, 3))
    else $error("external fall not from pin edge");
  a_sck_idle_high: assert property (@(posedge sys_clk) // [R14]
    disable iff (!rst_n) !transfer_go_r |=> sck)
    else $error("shift clock moved while idle");
  a_irq_masked: assert property (@(posedge sys_clk) // [R8]
    disable iff (!rst_n) !mask_r |=> !irq_r)
    else $error("interrupt raised while masked");
  c_full_transfer: cover property (@(posedge sys_clk)
    disable iff (!rst_n) last_rise);
  c_receive_only: cover property (@(posedge sys_clk)
    disable iff (!rst_n) last_rise && tx_output_float_r);
  c_ext_clock: cover property (@(posedge sys_clk)
    disable iff (!rst_n) last_rise && clk_sel_r == SEL_EXT);
  c_irq: cover property (@(posedge sys_clk)
    disable iff (!rst_n) $rose(irq_r));
  c_port_mode: cover property (@(posedge sys_clk)
    disable iff (!rst_n) wr && hit_port && !serial_pin_enable_r);
endmodule
`default_nettype wire

// ===== sim/serial_peer.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Remote serial peer
module serial_peer (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic so,
  input wire logic start,
  input wire logic ext_mode,
  input wire logic [7:0] tx_byte,
  output logic si,
  output logic ext_sck,
  output logic [7:0] rx_byte
);
  logic sck_q;
  logic [2:0] cnt;
  logic [2:0] hc;
  logic [4:0] edges;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q <= 1'b1;
      cnt <= 3'h0;
      hc <= 3'h0;
      edges <= 5'h00;
      si <= 1'b0;
      ext_sck <= 1'b1;
      rx_byte <= 8'h00;
    end else begin
      sck_q <= sck;
      if (start) begin
        hc <= 3'h0;
        edges <= ext_mode ? 5'h10 : 5'h00;
      end else if (edges != 5'h00) begin
        hc <= hc + 3'h1;
        if (hc == 3'h7) begin
          ext_sck <= ~ext_sck;
          edges <= edges - 5'h01;
        end
      end
      if (sck_q && !sck) si <= tx_byte[3'h7 - cnt];
      if (start) cnt <= 3'h0;
      else if (!sck_q && sck) cnt <= cnt + 3'h1;
      if (!sck_q && sck) rx_byte <= {rx_byte[6:0], so};
    end
  end
endmodule
`default_nettype wire

// ===== sim/clocked_serial_shift_port_bench.sv
`timescale 1ns/100ps
`default_nettype none
module clocked_serial_shift_port_bench;
  import sio_pkg::*;
  typedef struct packed {
    logic [1:0] sel;
    logic [7:0] tx;
    logic [7:0] px;
    logic [9:0] half;
  } row_t;
  row_t rows [4];
  logic sys_clk, rst_n, psel, penable, pwrite, start, fpat, emode;
  logic [7:0] paddr, ptx;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, irq, serr;
  logic [2:0] o, oe_n;
  wire logic l0, l1, l2, si, ext_sck;
  logic [7:0] prx;
  int err_total, tests_run, cyc, n;
  assign l0 = !oe_n[0] ? o[0] : ext_sck;
  assign l1 = !oe_n[1] ? o[1] : fpat;
  assign l2 = !oe_n[2] ? o[2] : si;
  clocked_serial_shift_port clocked_serial_shift_port_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .port_d_line0_in(l0), .port_d_line0_out(o[0]),
    .port_d_line0_oe_n(oe_n[0]), .port_d_line1_in(l1),
    .port_d_line1_out(o[1]), .port_d_line1_oe_n(oe_n[1]),
    .port_d_line2_in(l2), .port_d_line2_out(o[2]),
    .port_d_line2_oe_n(oe_n[2]));
  serial_peer serial_peer_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .sck(l0), .so(l1), .start(start),
    .ext_mode(emode), .tx_byte(ptx), .si(si), .ext_sck(ext_sck),
    .rx_byte(prx));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    fpat <= ~fpat;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(string nm, logic [32:0] seen, logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic go(logic [7:0] c, logic [7:0] sv, logic [7:0] pv);
    ptx <= pv;
    emode <= (c[1:0] == SEL_EXT);
    apb(1'b1, SHIFT_ADDR, {24'h0, sv});
    apb(1'b1, CTRL_ADDR, {24'h0, c});
    apb(1'b1, CTRL_ADDR, {24'h0, c | 8'h10});
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
  endtask
  initial begin
    {psel, penable, pwrite, start, fpat, emode, cyc, err_total,
     tests_run} = 0;
    {paddr, pwdata, ptx} = 0;
    rst_n = 1'b0;
    rows[0] = {SEL_D16, 8'hA5, 8'h3C, 10'(HALF16)};
    rows[1] = {SEL_D128, 8'h01, 8'h80, 10'(HALF128)};
    rows[2] = {SEL_D1024, 8'h80, 8'h01, 10'(HALF1024)};
    rows[3] = {SEL_EXT, 8'h6E, 8'hD3, 10'd8};
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    apb(1'b1, MASK_ADDR, 32'h1);
    foreach (rows[i]) begin
      go({6'h01, rows[i].sel}, rows[i].tx, rows[i].px);
      apb(1'b0, STAT_ADDR, 0);
      check("go status", rd, 32'h2);
      check("irq cleared", irq, 1'b0);
      for (n = 0; n < 3000 && l0 !== 1'b0; n++) @(posedge sys_clk);
      check("clk drive", oe_n[0], rows[i].sel == SEL_EXT);
      for (n = 0; n < 3000 && l0 === 1'b0; n++) @(posedge sys_clk);
      check("low half", n, rows[i].half);
      for (n = 0; n < 20000 && irq !== 1'b1; n++) @(posedge sys_clk);
      apb(1'b0, SHIFT_ADDR, 0);
      check("shift in", rd, rows[i].px);
      check("peer in", prx, rows[i].tx);
      apb(1'b0, CTRL_ADDR, 0);
      check("go clear", rd[CTRL_GO], 1'b0);
      $display("test row %0d finished", i);
    end
    apb(1'b0, STAT_ADDR, 0);
    check("done", rd, 32'h1);
    apb(1'b0, STAT_ADDR, 0);
    check("done clr", {irq, rd}, 33'h0);
    apb(1'b1, MASK_ADDR, 32'h0);
    go(8'h0D, 8'hFF, 8'h96);
    for (n = 0; n < 3000 && l0 !== 1'b0; n++) @(posedge sys_clk);
    check("float", oe_n[1], 1'b1);
    rd = 32'h2;
    for (n = 0; n < 900 && rd[STAT_BUSY] !== 1'b0; n++)
      apb(1'b0, STAT_ADDR, 0);
    check("masked", {irq, rd}, 33'h1);
    apb(1'b0, SHIFT_ADDR, 0);
    check("rx only", rd, 32'h96);
    $display("test float finished");
    rst_n <= 1'b0;
    @(posedge sys_clk);
    check("rst pins", {irq, o, oe_n}, 7'h3F);
    rst_n <= 1'b1;
    apb(1'b0, SHIFT_ADDR, 0);
    check("rst shift", rd, SHIFT_RST);
    apb(1'b0, PORT_ADDR, 0);
    check("rst port", rd[6:0], {DIR_RST, 1'b0, LATCH_RST});
    apb(1'b0, MASK_ADDR, 0);
    check("rst mask", rd, MASK_RST);
    apb(1'b1, PORT_ADDR, 32'h75);
    repeat (2) @(posedge sys_clk);
    check("gp port", {o, oe_n}, 6'h28);
    apb(1'b0, PORT_ADDR, 0);
    check("gp pins", rd[10:8], 3'h5);
    apb(1'b1, CTRL_ADDR, 32'h10);
    apb(1'b0, STAT_ADDR, 0);
    check("go refused", rd, 32'h0);
    apb(1'b1, CTRL_ADDR, 32'h05);
    apb(1'b1, PORT_ADDR, 32'h70);
    repeat (2) @(posedge sys_clk);
    check("latch lo", o[1], 1'b0);
    apb(1'b1, PORT_ADDR, 32'h72);
    repeat (2) @(posedge sys_clk);
    check("latch hi", o[1], 1'b1);
    apb(1'b1, SHIFT_ADDR, 32'hFFFFFF5A);
    apb(1'b0, SHIFT_ADDR, 0);
    check("store", {l0, rd}, 33'h10000005A);
    apb(1'b0, 8'hF0, 0);
    check("unmapped", {serr, rd}, 33'h100000000);
    $display("test hand finished");
    complete_run();
  end
endmodule
`default_nettype wire
